// >>> rtl/ssp_packet.sv
// Packet layer of a stackable SPI slave: framing, check byte, broadcast and address discovery.
//
// Overview of operation
// - Write data enters on the south input and is relayed north.
// - Bad or missing check byte on a write raises the south alert.
// - Writes to address 0x3f are taken by every validly addressed device.
// - Writes carry one data byte; first byte is address shifted left plus write bit.
// - Order: address, offset, length for reads, data, then check byte; only writes can disable it.
// - The data supplier appends the check byte; both ends compute it.
// - Check byte is CRC-8 with polynomial x^8+x^2+x+1, MSB first.
// - Read check covers address, offset, length and returned data, not dummy bytes.
// - Check at chip select release; on failure drop, flag, latch fault output.
// - The check flag stays set after a failed packet until a host write of one to it or a reset clears it.
// - Reset clears address request, zeroes address and raises south alert.
// - At address zero the north chip select is held deasserted.
// - With a valid address north chip select follows south chip select.
// - Address write sets request bit, mirrors it, releases alert, opens north select.
// - A device at address zero blocks traffic to devices above it.
// - Vertical chip select is active high; only the matching device answers.
// - Reserved locations and unused bits read as zero.
// - Read-only registers reset and change only through internal updates.
// - Read/write registers reset and each write packet changes one register.
// - Write data is held until the check passes, else discarded.
// - Serial mode 1: clock idles low, launch on rise, sample on fall.
// - Chip select assertion resets and realigns the serial receiver.
// - The addressed device drives read data south, then a check byte.
`timescale 1ns/1ps
module ssp_packet
  import ssp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic south_sclk_i,
  input wire logic south_cs_n_i,
  input wire logic south_serial_in_i,
  input wire logic north_return_in_i,
  input wire logic north_alert_i,
  input wire logic check_byte_disable_i,
  input wire ssp_wr_s int_wr_i,
  output logic north_sclk_o,
  output logic north_cs_o,
  output logic north_serial_out_o,
  output logic south_return_out_o,
  output logic south_alert_o,
  output logic fault_o,
  output logic [5:0] dev_addr_o,
  output logic address_request_flag_o,
  output logic crc_error_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection.

  logic [4:0] s1_q;
  logic [4:0] s2_q;
  logic sclk_prev_q;
  logic csn_prev_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= 5'h1e;
      s2_q <= 5'h1e;
      sclk_prev_q <= 1'b0;
      csn_prev_q <= 1'b1;
    end else begin
      s1_q <= {north_alert_i, north_return_in_i, south_serial_in_i, south_cs_n_i, south_sclk_i};
      s2_q <= s1_q;
      sclk_prev_q <= s2_q[0];
      csn_prev_q <= s2_q[1];
    end
  end

  logic sclk_s, csn_s, south_serial_in, ret_s, nalert_s;
  assign sclk_s = s2_q[0];
  assign csn_s = s2_q[1];
  assign south_serial_in = s2_q[2];
  assign ret_s = s2_q[3];
  assign nalert_s = s2_q[4];

  logic cs_start, cs_end, sclk_fall, sclk_rise;
  assign cs_start = csn_prev_q && !csn_s;
  assign cs_end = !csn_prev_q && csn_s;
  assign sclk_fall = !csn_s && sclk_prev_q && !sclk_s;
  assign sclk_rise = !csn_s && !sclk_prev_q && sclk_s;

  ////////////////////////////////////////////////////////////////////////////////
  // Bit receiver.

  logic [7:0] rx_q;
  logic [2:0] bitcnt_q;
  logic byte_done;
  logic [7:0] rx_byte;
  assign byte_done = sclk_fall && (bitcnt_q == SSP_LAST_BIT);
  assign rx_byte = {rx_q[6:0], south_serial_in};

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_q <= 8'h00;
      bitcnt_q <= 3'h0;
    end else if (cs_start) begin
      bitcnt_q <= 3'h0;
    end else if (sclk_fall) begin
      rx_q <= rx_byte;
      bitcnt_q <= bitcnt_q + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Packet sequencer.

  ssp_state_e state_q;
  logic is_wr_q;
  logic [7:0] off_q;
  logic [7:0] len_q;
  logic [7:0] idx_q;
  logic [7:0] wdata_q;
  logic [7:0] crc_q;
  logic [7:0] tx_byte_q;
  logic [7:0] rd_ptr_q;
  logic [5:0] addr_q;
  logic ar_q;
  logic reset_alert_q;
  logic soft_rst_q;
  logic [7:0] fault_q;
  logic [7:0] mem_rdata;
  logic addr_valid;
  logic hdr_match;
  assign addr_valid = ssp_addr_valid(addr_q);
  // A broadcast is never taken at address zero, so discovery cannot be disturbed by it.
  assign hdr_match = !rx_byte[7] && ((rx_byte[6:1] == addr_q) ||
                     (rx_byte[6:1] == SSP_ADDR_BCAST && addr_valid));

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_ADDR;
      is_wr_q <= 1'b0;
      off_q <= 8'h00;
      len_q <= 8'h00;
      idx_q <= 8'h00;
      wdata_q <= 8'h00;
    end else if (soft_rst_q || cs_start) begin
      state_q <= ST_ADDR;
      is_wr_q <= 1'b0;
      idx_q <= 8'h00;
    end else if (byte_done) begin
      unique case (state_q)
        ST_ADDR: begin
          is_wr_q <= rx_byte[0];
          state_q <= hdr_match ? ST_OFFS : ST_SKIP;
        end
        ST_OFFS: begin
          off_q <= rx_byte;
          state_q <= is_wr_q ? ST_WDATA : ST_LEN;
        end
        ST_LEN: begin
          len_q <= rx_byte;
          idx_q <= 8'h00;
          state_q <= ST_RDATA;
        end
        ST_WDATA: begin
          wdata_q <= rx_byte;
          state_q <= check_byte_disable_i ? ST_DONE : ST_WCRC;
        end
        ST_WCRC: state_q <= ST_DONE;
        ST_RDATA: begin
          if (idx_q == len_q) begin
            state_q <= ST_DONE;
          end else begin
            idx_q <= idx_q + 8'h01;
          end
        end
        ST_DONE: state_q <= ST_DONE;
        ST_SKIP: state_q <= ST_SKIP;
      endcase
    end
  end

  // The running check covers every request byte and, while sending, the byte just sent.
  logic [7:0] crc_nxt;
  assign crc_nxt = ssp_crc8(crc_q, (state_q == ST_RDATA) ? tx_byte_q : rx_byte);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      crc_q <= SSP_CRC_INIT;
    end else if (cs_start) begin
      crc_q <= SSP_CRC_INIT;
    end else if (byte_done && state_q != ST_DONE && state_q != ST_SKIP) begin
      crc_q <= crc_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data path.

  logic [7:0] rd_val;
  always_comb begin
    rd_val = 8'h00;
    if (rd_ptr_q == SSP_OFF_DEV_STATUS) begin
      rd_val = mem_rdata;
      rd_val[SSP_DSTAT_AR_BIT] = ar_q;
    end else if (rd_ptr_q == SSP_OFF_FAULT) begin
      rd_val = fault_q;
    end else if (rd_ptr_q == SSP_OFF_ADDR_CTRL) begin
      rd_val = {ar_q, 1'b0, addr_q};
    end else if (ssp_is_host_rw(rd_ptr_q) || ssp_is_internal(rd_ptr_q)) begin
      rd_val = mem_rdata;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_byte_q <= 8'h00;
      rd_ptr_q <= 8'h00;
    end else if (byte_done && state_q == ST_OFFS) begin
      rd_ptr_q <= rx_byte;
    end else if (byte_done && state_q == ST_LEN) begin
      tx_byte_q <= (rx_byte == 8'h00) ? crc_nxt : rd_val;
      rd_ptr_q <= rd_ptr_q + 8'h01;
    end else if (byte_done && state_q == ST_RDATA) begin
      tx_byte_q <= (idx_q + 8'h01 == len_q) ? crc_nxt : rd_val;
      rd_ptr_q <= rd_ptr_q + 8'h01;
    end
  end

  // Read data goes out on rising edges; otherwise the return line is relayed from above.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      south_return_out_o <= 1'b0;
    end else if (state_q == ST_RDATA) begin
      if (sclk_rise) begin
        south_return_out_o <= tx_byte_q[~bitcnt_q];
      end
    end else begin
      south_return_out_o <= ret_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // End of packet: check and commit.

  logic wr_pkt, crc_ok, crc_fail, commit;
  assign wr_pkt = cs_end && is_wr_q && state_q != ST_ADDR && state_q != ST_SKIP;
  assign crc_ok = check_byte_disable_i || (crc_q == 8'h00);
  // A packet that ends before its check byte never reaches the done state.
  assign crc_fail = wr_pkt && !check_byte_disable_i && (state_q != ST_DONE || !crc_ok);
  assign commit = wr_pkt && state_q == ST_DONE && crc_ok;

  ssp_wr_s mem_wr;
  always_comb begin
    mem_wr = '0;
    if (commit && ssp_is_host_rw(off_q)) begin
      mem_wr = '{we: 1'b1, addr: off_q[5:0], data: wdata_q};
    end else if (int_wr_i.we && ssp_is_internal({2'b00, int_wr_i.addr})) begin
      mem_wr = int_wr_i;
    end
  end

  ssp_regmem #(
    .DEPTH(64)
  ) u_mem (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .clear_i(soft_rst_q),
    .wr_i(mem_wr),
    .rd_addr_i(rd_ptr_q[5:0]),
    .rd_data_o(mem_rdata)
  );

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= commit && off_q == SSP_OFF_RESET && wdata_q == SSP_RESET_CMD;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_q <= SSP_ADDR_DISCOVER;
      ar_q <= 1'b0;
      reset_alert_q <= 1'b1;
    end else if (soft_rst_q) begin
      addr_q <= SSP_ADDR_DISCOVER;
      ar_q <= 1'b0;
      reset_alert_q <= 1'b1;
    end else if (commit && off_q == SSP_OFF_ADDR_CTRL) begin
      addr_q <= wdata_q[5:0];
      ar_q <= 1'b1;
      reset_alert_q <= 1'b0;
    end
  end

  // Host writes clear the bits written as one; a failure in the same cycle still sets its flag.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_q <= SSP_FAULT_RST;
    end else if (soft_rst_q) begin
      fault_q <= SSP_FAULT_RST;
    end else begin
      fault_q <= ((commit && off_q == SSP_OFF_FAULT) ? (fault_q & ~wdata_q) : fault_q) |
                 (crc_fail ? (8'h01 << SSP_FAULT_CRC_BIT) : 8'h00);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Stack relay and status outputs.

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      north_cs_o <= 1'b0;
      north_sclk_o <= 1'b0;
      north_serial_out_o <= 1'b0;
      south_alert_o <= 1'b1;
      fault_o <= 1'b1;
    end else begin
      north_cs_o <= addr_valid && !csn_s;
      north_sclk_o <= addr_valid && sclk_s;
      north_serial_out_o <= addr_valid && south_serial_in;
      south_alert_o <= reset_alert_q || nalert_s || fault_q[SSP_FAULT_CRC_BIT];
      fault_o <= |fault_q;
    end
  end

  assign dev_addr_o = addr_q;
  assign address_request_flag_o = ar_q;
  assign crc_error_o = fault_q[SSP_FAULT_CRC_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence seq_bad_end;
    crc_fail;
  endsequence

  sequence seq_flag_raised;
    fault_q[SSP_FAULT_CRC_BIT] ##1 (south_alert_o && fault_o);
  endsequence

  a_north_cs_block: assert property (addr_q == SSP_ADDR_DISCOVER |=> !north_cs_o)
    else $error("north select passed at address zero");
  a_north_cs_follow: assert property (addr_valid && !csn_s && $stable(addr_q) |=> north_cs_o)
    else $error("north select does not follow south select");
  a_crc_flag_alert: assert property (seq_bad_end |=> seq_flag_raised)
    else $error("check failure did not raise flag, alert and fault");
  a_bad_crc_drop: assert property (crc_fail |-> !(mem_wr.we && !int_wr_i.we)
    ##1 ($stable(addr_q) && $stable(ar_q) && !soft_rst_q))
    else $error("bad packet was committed");
  a_addr_assign: assert property (commit && off_q == SSP_OFF_ADDR_CTRL |=> ar_q && addr_q == $past(wdata_q[5:0]))
    else $error("address write did not set request flag");
  a_alert_after_rst: assert property (soft_rst_q |=> reset_alert_q ##1 south_alert_o)
    else $error("reset command did not raise south alert");
  a_write_at_end: assert property (commit |-> $rose(csn_s) && $past(state_q) == ST_DONE)
    else $error("write committed outside packet end");
  a_ro_protect: assert property (mem_wr.we && !commit |-> ssp_is_internal({2'b00, mem_wr.addr}))
    else $error("internal update hit a host register");
  a_rx_resync: assert property (cs_start |=> bitcnt_q == 3'h0 && state_q == ST_ADDR)
    else $error("receiver not realigned at select");
  a_tx_check_byte: assert property (byte_done && state_q == ST_RDATA && idx_q == len_q
    |=> crc_q == 8'h00)
    else $error("read did not end with check byte");
  a_reserved_zero: assert property (byte_done && state_q == ST_LEN && rx_byte != 8'h00 &&
    (rd_ptr_q >= SSP_OFF_MAP_END || (rd_ptr_q > SSP_OFF_G1B_LAST && rd_ptr_q < SSP_OFF_G2_FIRST) ||
    (rd_ptr_q > SSP_OFF_G1_LAST && rd_ptr_q < SSP_OFF_ALERT)) |=> tx_byte_q == 8'h00)
    else $error("reserved location read non zero");

endmodule : ssp_packet

// >>> rtl/ssp_pkg.sv
// Constants, types and helper functions shared by the stacked SPI packet layer.
package ssp_pkg;

  localparam logic [5:0] SSP_ADDR_DISCOVER = 6'h00;
  localparam logic [5:0] SSP_ADDR_BCAST = 6'h3f;

  localparam logic [7:0] SSP_OFF_DEV_STATUS = 8'h00;
  localparam logic [7:0] SSP_OFF_G1_LAST = 8'h12;
  localparam logic [7:0] SSP_OFF_ALERT = 8'h20;
  localparam logic [7:0] SSP_OFF_FAULT = 8'h21;
  localparam logic [7:0] SSP_OFF_G1B_FIRST = 8'h22;
  localparam logic [7:0] SSP_OFF_G1B_LAST = 8'h25;
  localparam logic [7:0] SSP_OFF_G2_FIRST = 8'h30;
  localparam logic [7:0] SSP_OFF_G2_LAST = 8'h34;
  localparam logic [7:0] SSP_OFF_SHADOW = 8'h3a;
  localparam logic [7:0] SSP_OFF_ADDR_CTRL = 8'h3b;
  localparam logic [7:0] SSP_OFF_RESET = 8'h3c;
  localparam logic [7:0] SSP_OFF_TEST = 8'h3d;
  localparam logic [7:0] SSP_OFF_EPROM_EN = 8'h3f;
  localparam logic [7:0] SSP_OFF_MAP_END = 8'h40;

  localparam logic [7:0] SSP_ALERT_RST = 8'h80;
  localparam logic [7:0] SSP_FAULT_RST = 8'h08;
  localparam int SSP_FAULT_CRC_BIT = 4;
  localparam int SSP_DSTAT_AR_BIT = 6;
  localparam int SSP_ACTL_AR_BIT = 7;
  localparam logic [7:0] SSP_RESET_CMD = 8'ha5;

  localparam logic [7:0] SSP_CRC_POLY = 8'h07;
  localparam logic [7:0] SSP_CRC_INIT = 8'h00;
  localparam logic [2:0] SSP_LAST_BIT = 3'h7;

  typedef enum logic [2:0] {
    ST_ADDR = 3'b000,
    ST_OFFS = 3'b001,
    ST_LEN = 3'b010,
    ST_WDATA = 3'b011,
    ST_WCRC = 3'b100,
    ST_RDATA = 3'b101,
    ST_DONE = 3'b110,
    ST_SKIP = 3'b111
  } ssp_state_e;

  typedef struct packed {
    logic we;
    logic [5:0] addr;
    logic [7:0] data;
  } ssp_wr_s;

  function automatic logic [7:0] ssp_crc8(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ({c[6:0], 1'b0} ^ SSP_CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction : ssp_crc8

  function automatic logic ssp_addr_valid(input logic [5:0] a);
    return (a != SSP_ADDR_DISCOVER) && (a != SSP_ADDR_BCAST);
  endfunction : ssp_addr_valid

  // Locations a host write stores into the register memory.
  function automatic logic ssp_is_host_rw(input logic [7:0] off);
    return (off == SSP_OFF_ALERT) || (off >= SSP_OFF_G2_FIRST && off <= SSP_OFF_G2_LAST) ||
           (off == SSP_OFF_SHADOW) || (off == SSP_OFF_TEST) || (off == SSP_OFF_EPROM_EN);
  endfunction : ssp_is_host_rw

  // Locations that the device's own logic updates; SSP_OFF_ALERT also takes host writes.
  function automatic logic ssp_is_internal(input logic [7:0] off);
    return (off <= SSP_OFF_G1_LAST) || (off == SSP_OFF_ALERT) ||
           (off >= SSP_OFF_G1B_FIRST && off <= SSP_OFF_G1B_LAST);
  endfunction : ssp_is_internal

  function automatic logic [7:0] ssp_reset_value(input logic [7:0] off);
    return (off == SSP_OFF_ALERT) ? SSP_ALERT_RST : 8'h00;
  endfunction : ssp_reset_value

endpackage : ssp_pkg

// >>> rtl/ssp_regmem.sv
// Register memory of the packet layer with a registered read port.
`timescale 1ns/1ps
module ssp_regmem
  import ssp_pkg::*;
#(
  parameter int DEPTH = 64
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clear_i,
  input wire ssp_wr_s wr_i,
  input wire logic [5:0] rd_addr_i,
  output logic [7:0] rd_data_o
);

  logic [7:0] mem_q [DEPTH];

  for (genvar g = 0; g < DEPTH; g++) begin : g_word
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        mem_q[g] <= ssp_reset_value(8'(g));
      end else if (clear_i) begin
        mem_q[g] <= ssp_reset_value(8'(g));
      end else if (wr_i.we && wr_i.addr == 6'(g)) begin
        mem_q[g] <= wr_i.data;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= 8'h00;
    end else begin
      rd_data_o <= mem_q[rd_addr_i];
    end
  end

endmodule : ssp_regmem

// >>> testbench/ssp_host_model.sv
// Host serial master model with the return line of the stacked device above.
`timescale 1ns/1ps
module ssp_host_model (
  input wire logic clk_i,
  input wire logic sdo_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o,
  output logic north_ret_o
);
  // Eight system clocks a half period give the 160 ns serial period.
  localparam int HALF = 8;
  logic [7:0] crc_q;

  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
    north_ret_o = 1'b0;
    crc_q = 8'h00;
  end

  // The unselected device above toggles, so a stale level is never taken for a reply.
  always @(negedge clk_i) north_ret_o <= ~north_ret_o;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] crc_upd(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
    end
    return r;
  endfunction : crc_upd

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_i);
  endtask : wait_clk

  // Launch on the rising edge, let the device sample on the falling edge, MSB first.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sclk_o <= 1'b1;
      sdi_o <= tx[i];
      wait_clk(HALF);
      sclk_o <= 1'b0;
      rx[i] = sdo_i;
      wait_clk(HALF);
    end
  endtask : xfer

  task automatic open_pkt();
    wait_clk(1);
    cs_n_o <= 1'b0;
    crc_q = 8'h00;
    wait_clk(HALF);
  endtask : open_pkt

  task automatic close_pkt();
    cs_n_o <= 1'b1;
    sdi_o <= 1'b0;
    wait_clk(12);
  endtask : close_pkt

  // Sends the first nbytes of header, offset, data and check byte; crc_x corrupts the check byte.
  task automatic write(input logic [5:0] a, input logic [7:0] off, input logic [7:0] d,
                       input logic [7:0] crc_x, input int nbytes);
    logic [7:0] b [4];
    logic [7:0] rx;
    b[0] = {1'b0, a, 1'b1};
    b[1] = off;
    b[2] = d;
    b[3] = crc_upd(crc_upd(crc_upd(8'h00, b[0]), b[1]), b[2]) ^ crc_x;
    open_pkt();
    for (int k = 0; k < nbytes; k++) begin
      xfer(b[k], rx);
    end
    close_pkt();
  endtask : write

  // Read packet: n data bytes plus the check byte are clocked out with 0x00 dummies.
  task automatic read(input logic [5:0] a, input logic [7:0] off, input int n,
                      output logic [7:0] got [5], output logic [7:0] exp_crc);
    logic [7:0] rx;
    open_pkt();
    xfer({1'b0, a, 1'b0}, rx);
    crc_q = crc_upd(crc_q, {1'b0, a, 1'b0});
    xfer(off, rx);
    crc_q = crc_upd(crc_q, off);
    xfer(8'(n), rx);
    crc_q = crc_upd(crc_q, 8'(n));
    for (int k = 0; k <= n; k++) begin
      xfer(8'h00, got[k]);
      if (k < n) begin
        crc_q = crc_upd(crc_q, got[k]);
      end
    end
    exp_crc = crc_q;
    close_pkt();
  endtask : read

endmodule : ssp_host_model

// >>> testbench/ssp_packet_tb.sv
// Self-checking testbench of the stacked SPI packet layer.
`timescale 1ns/1ps
module ssp_packet_tb;
  import ssp_pkg::*;

  typedef struct packed {
    logic [5:0] a;
    logic [7:0] off;
    logic [7:0] d;
    logic [7:0] exp;
  } ssp_row_s;

  logic clk, rst_n, cbd, nalert, sclk, cs_n, sdi, nret;
  logic [2:0] north_seen;
  logic nsclk, ncs, nsdo, sret, salert, fault, flag, crc_err;
  logic [5:0] dev_addr;
  ssp_wr_s iw;
  logic [7:0] got [5];
  logic [7:0] ecrc;
  int errors, tests_run;
  ssp_row_s rows [6];

  ssp_packet i_dut (.clk_i(clk), .rst_n_i(rst_n), .south_sclk_i(sclk), .south_cs_n_i(cs_n),
    .south_serial_in_i(sdi), .north_return_in_i(nret), .north_alert_i(nalert),
    .check_byte_disable_i(cbd), .int_wr_i(iw), .north_sclk_o(nsclk), .north_cs_o(ncs),
    .north_serial_out_o(nsdo), .south_return_out_o(sret), .south_alert_o(salert), .fault_o(fault),
    .dev_addr_o(dev_addr), .address_request_flag_o(flag), .crc_error_o(crc_err));

  ssp_host_model i_host (.clk_i(clk), .sdo_i(sret), .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi),
    .north_ret_o(nret));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) north_seen <= north_seen | {nsdo === 1'b1, nsclk === 1'b1, ncs === 1'b1};

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    if (errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  // Reads one byte from our own address and checks both the data and the returned check byte.
  task automatic read_one(input logic [7:0] off, input logic [7:0] exp);
    i_host.read(6'h05, off, 1, got, ecrc);
    check(got[0], exp);
    check(got[1], ecrc);
  endtask : read_one

  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    results();
  end

  initial begin
    rst_n = 1'b0;
    cbd = 1'b0;
    nalert = 1'b0;
    iw = '0;
    north_seen = '0;
    errors = 0;
    tests_run = 0;
    rows[0] = {6'h05, 8'h30, 8'h5a, 8'h5a};
    rows[1] = {6'h3f, 8'h31, 8'h3c, 8'h3c};
    rows[2] = {6'h07, 8'h32, 8'h11, 8'h00};
    rows[3] = {6'h05, 8'h3d, 8'h00, 8'h00};
    rows[4] = {6'h05, 8'h01, 8'h66, 8'h00};
    rows[5] = {6'h05, 8'h33, 8'h81, 8'h81};
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    i_host.wait_clk(4);
    check(8'({salert, fault, flag, crc_err, ncs}), 8'h18);
    check(8'(dev_addr), 8'h00);
    // Address discovery: the device at zero must keep everything above it quiet.
    i_host.write(6'h00, SSP_OFF_ADDR_CTRL, 8'h05, 8'h00, 4);
    check(8'(north_seen), 8'h00);
    check(8'(dev_addr), 8'h05);
    check(8'({salert, flag}), 8'h01);
    for (int r = 0; r < 6; r++) begin
      i_host.write(rows[r].a, rows[r].off, rows[r].d, 8'h00, 4);
      read_one(rows[r].off, rows[r].exp);
    end
    check(8'(north_seen), 8'h07);
    // Multi-byte read and the shortest read, which returns only the check byte.
    i_host.read(6'h05, 8'h2f, 4, got, ecrc);
    check(got[0], 8'h00);
    check(got[1], 8'h5a);
    check(got[2], 8'h3c);
    check(got[4], ecrc);
    i_host.read(6'h05, 8'h30, 0, got, ecrc);
    check(got[0], ecrc);
    // A corrupted check byte must leave the target untouched and latch the fault.
    // The fault output is high from reset, so that source is cleared first to see the failure raise it.
    i_host.write(6'h05, SSP_OFF_FAULT, SSP_FAULT_RST, 8'h00, 4);
    check(8'(fault), 8'h00);
    i_host.write(6'h05, 8'h30, 8'h99, 8'h01, 4);
    check(8'({salert, fault, crc_err}), 8'h07);
    read_one(8'h30, 8'h5a);
    read_one(SSP_OFF_FAULT, 8'h10);
    i_host.write(6'h05, SSP_OFF_FAULT, 8'h10, 8'h00, 4);
    check(8'({salert, fault, crc_err}), 8'h00);
    // A packet cut after its offset byte has no check byte at all.
    i_host.write(6'h05, 8'h34, 8'h42, 8'h00, 2);
    check(8'({salert, crc_err}), 8'h03);
    i_host.write(6'h05, SSP_OFF_FAULT, 8'h10, 8'h00, 4);
    check(8'(crc_err), 8'h00);
    cbd = 1'b1;
    i_host.write(6'h05, 8'h34, 8'h42, 8'h00, 3);
    i_host.read(6'h05, 8'h34, 1, got, ecrc);
    check(got[0], 8'h42);
    cbd = 1'b0;
    nalert = 1'b1;
    i_host.wait_clk(6);
    check(8'(salert), 8'h01);
    nalert = 1'b0;
    iw <= '{we: 1'b1, addr: 6'h03, data: 8'hc4};
    @(negedge clk);
    iw <= '0;
    read_one(8'h03, 8'hc4);
    // The reset command must return address, flag and alert to their reset state.
    i_host.write(6'h05, SSP_OFF_RESET, SSP_RESET_CMD, 8'h00, 4);
    check({salert, flag, dev_addr}, 8'h80);
    // After the reset command the device answers at zero again, so it is readdressed before the read.
    i_host.write(6'h00, SSP_OFF_ADDR_CTRL, 8'h05, 8'h00, 4);
    read_one(8'h30, 8'h00);
    results();
  end

endmodule : ssp_packet_tb
